// ==== rtl/dtisc_pkg.sv ====
// Package for the dead-time and idle-state control block
`default_nettype none

package dtisc_pkg;

    // ********************************************
    // Register indices (byte address = 4 * index)
    // ********************************************
    localparam logic [7:0] IDX_COUNTER_CONTROL_ONE = 8'h00;
    localparam logic [7:0] IDX_DEADTIME_SETUP      = 8'h1e;
    localparam logic [7:0] IDX_OUTPUT_IDLE_LEVELS  = 8'h1f;
    localparam logic [7:0] IDX_OUTPUT_GATE_CTRL    = 8'h20;
    localparam logic [7:0] IDX_CHANNEL_ENABLES     = 8'h21;
    localparam logic [7:0] IDX_OUTPUT_STATUS       = 8'h22;

    // ********************************************
    // Reset values and field positions
    // ********************************************
    localparam logic [7:0] RST_COUNTER_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_DEADTIME_SETUP      = 8'h00;
    localparam logic [7:0] RST_OUTPUT_IDLE_LEVELS  = 8'h00;
    localparam logic [7:0] RST_CHANNEL_ENABLES     = 8'h00;
    localparam int         POS_MAIN_OUTPUT_GATE    = 7;
    localparam int         POS_LOCK_HI             = 1;
    localparam int         POS_LOCK_LO             = 0;
    localparam logic [1:0] LOCK_OFF                = 2'h0;

    // ********************************************
    // Dead-time ranges and prescaler
    // ********************************************
    localparam int         DT_W          = 11;
    localparam logic [6:0] DT_BASE_64    = 7'h40;
    localparam logic [6:0] DT_BASE_32    = 7'h20;
    localparam logic [3:0] PSC_RELOAD    = 4'h1;

    // Idle level register layout, bit 7 reserved
    typedef struct packed {
        logic reserved;
        logic idle_level_ch4_main;
        logic idle_level_ch3_comp;
        logic idle_level_ch3_main;
        logic idle_level_ch2_comp;
        logic idle_level_ch2_main;
        logic idle_level_ch1_comp;
        logic idle_level_ch1_main;
    } dtisc_idle_t;

    // Main and complementary level of one channel
    typedef struct packed {
        logic main;
        logic comp;
    } dtisc_pair_t;

    // Dead time in prescaled clock periods from the 8-bit setting
    function automatic logic [DT_W-1:0] deadtime_length(
        input logic [7:0] setup
    );
        logic [DT_W-1:0] len;
        len = '0;
        if (!setup[7]) begin
            len = {3'h0, setup};
        end else if (!setup[6]) begin
            len = {3'h0, DT_BASE_64 + {1'b0, setup[5:0]}, 1'b0};
        end else if (!setup[5]) begin
            len = {2'h0, DT_BASE_32[5:0] + {1'b0, setup[4:0]}, 3'h0};
        end else begin
            len = {1'b0, DT_BASE_32[5:0] + {1'b0, setup[4:0]}, 4'h0};
        end
        return len;
    endfunction : deadtime_length

endpackage : dtisc_pkg

`default_nettype wire

// ==== rtl/dtisc_deadtime_gen.sv ====
// One channel of dead-time insertion for a main/complementary pair
`default_nettype none

module dtisc_deadtime_gen
    import dtisc_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    // Timing
    input  wire logic              psc_tick_i,
    input  wire logic [DT_W-1:0]   dt_len_i,
    // Levels
    input  wire dtisc_pair_t       want_i,
    output var  dtisc_pair_t       pair_o
);

    dtisc_pair_t      want_q;
    logic [DT_W-1:0]  cnt_q;

    // ********************************************
    // Change tracking and dead-time counter
    // ********************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            want_q <= '0;
            cnt_q  <= '0;
        end else if (want_i != want_q) begin
            want_q <= want_i;
            cnt_q  <= dt_len_i;
        end else if (cnt_q != '0 && psc_tick_i) begin
            cnt_q  <= cnt_q - 1'b1;
        end
    end

    // ********************************************
    // Output levels
    // ********************************************
    // Falling edges pass at once, rising edges wait out the dead time,
    // so main and comp are never high together on a complementary swap.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pair_o <= '0;
        end else if (want_i != want_q) begin
            if (dt_len_i == '0) begin
                pair_o <= want_i;
            end else begin
                pair_o <= want_i & pair_o;
            end
        end else if (cnt_q == '0 || (cnt_q == DT_W'(1) && psc_tick_i)) begin
            pair_o <= want_q;
        end
    end

endmodule : dtisc_deadtime_gen

`default_nettype wire

// ==== rtl/dtisc_top.sv ====
// Dead-time insertion and output idle-state control with APB registers
`default_nettype none

// Contract
// - Dead time counted in prescaled clock periods
// - Top bit 0: setting times one period
// - Top bits 10: 64 plus low six, times two
// - Top bits 110: 32 plus low five, times eight
// - Top bits 111: 32 plus low five, times sixteen
// - Dead-time writes ignored under lock levels 1-3
// - Gate off: comp outputs idle after dead time
// - Gate off: main outputs idle, dead time if paired
// - Idle bits: pairs in 0-5, channel four bit 6
// - Idle-level writes ignored under lock levels 1-3
// - Idle register top bit always reads zero
// - Gate 0 forces idle; gate 1 follows enables
// - Lock level written once, frozen until reset
module dtisc_top
    import dtisc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Reference waveforms from the compare logic
    input  wire logic [3:0]  ref_wave_i,
    // Power stage outputs
    output logic      [3:0]  ch_main_out_o,
    output logic      [2:0]  ch_comp_out_o
);

    // ********************************************
    // Registers
    // ********************************************
    logic [7:0]       counter_control_one_q;
    logic [7:0]       deadtime_setup_q;
    dtisc_idle_t      output_idle_levels_q;
    logic             main_output_gate_q;
    logic [1:0]       lock_level_q;
    logic             lock_done_q;
    logic [6:0]       channel_enables_q;
    logic [3:0]       psc_cnt_q;
    logic             psc_tick_q;
    logic             ch4_main_q;
    logic [DT_W-1:0]  dt_len;
    dtisc_pair_t      want   [3];
    dtisc_pair_t      pair   [3];
    logic [7:0]       idle_bits;

    // ********************************************
    // APB decode
    // ********************************************
    logic        setup_ph;
    logic        wr_acc;
    logic [7:0]  idx;
    logic        idx_ok;
    logic [7:0]  rd_val;
    logic [7:0]  status_val;

    assign setup_ph  = psel_i && !penable_i;
    assign wr_acc    = psel_i && penable_i && pready_o && pwrite_i
                       && !pslverr_o;
    assign idx       = paddr_i[9:2];
    assign idle_bits = output_idle_levels_q;
    assign status_val = {lock_done_q, ch4_main_q,
                         pair[2].main, pair[1].main, pair[0].main,
                         pair[2].comp, pair[1].comp, pair[0].comp};

    always_comb begin
        idx_ok = 1'b1;
        rd_val = 8'h00;
        if (paddr_i[11:10] != 2'h0 || paddr_i[1:0] != 2'h0) begin
            idx_ok = 1'b0;
        end else if (idx == IDX_COUNTER_CONTROL_ONE) begin
            rd_val = counter_control_one_q;
        end else if (idx == IDX_DEADTIME_SETUP) begin
            rd_val = deadtime_setup_q;
        end else if (idx == IDX_OUTPUT_IDLE_LEVELS) begin
            rd_val = {1'b0, idle_bits[6:0]};
        end else if (idx == IDX_OUTPUT_GATE_CTRL) begin
            rd_val = {main_output_gate_q, 5'h00, lock_level_q};
        end else if (idx == IDX_CHANNEL_ENABLES) begin
            rd_val = {1'b0, channel_enables_q};
        end else if (idx == IDX_OUTPUT_STATUS) begin
            rd_val = status_val;
        end else begin
            idx_ok = 1'b0;
        end
    end

    // Answer prepared in setup, so the access phase has no wait state
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready_o  <= 1'b1;
            pslverr_o <= !idx_ok;
            prdata_o  <= {24'h00_0000, rd_val};
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // ********************************************
    // Register writes
    // ********************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            counter_control_one_q <= RST_COUNTER_CONTROL_ONE;
        end else if (wr_acc && idx == IDX_COUNTER_CONTROL_ONE) begin
            counter_control_one_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            deadtime_setup_q <= RST_DEADTIME_SETUP;
        end else if (wr_acc && idx == IDX_DEADTIME_SETUP
                     && lock_level_q == LOCK_OFF) begin
            deadtime_setup_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            output_idle_levels_q <= RST_OUTPUT_IDLE_LEVELS;
        end else if (wr_acc && idx == IDX_OUTPUT_IDLE_LEVELS
                     && lock_level_q == LOCK_OFF) begin
            output_idle_levels_q <= {1'b0, pwdata_i[6:0]};
        end
    end

    // Gate stays writable; the lock field takes only the first write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            main_output_gate_q <= 1'b0;
            lock_level_q       <= LOCK_OFF;
            lock_done_q        <= 1'b0;
        end else if (wr_acc && idx == IDX_OUTPUT_GATE_CTRL) begin
            main_output_gate_q <= pwdata_i[POS_MAIN_OUTPUT_GATE];
            lock_done_q        <= 1'b1;
            if (!lock_done_q) begin
                lock_level_q <= pwdata_i[POS_LOCK_HI:POS_LOCK_LO];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            channel_enables_q <= RST_CHANNEL_ENABLES[6:0];
        end else if (wr_acc && idx == IDX_CHANNEL_ENABLES) begin
            channel_enables_q <= pwdata_i[6:0];
        end
    end

    // ********************************************
    // Prescaled clock enable
    // ********************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            psc_cnt_q  <= PSC_RELOAD;
            psc_tick_q <= 1'b0;
        end else if (psc_cnt_q == 4'h0) begin
            psc_cnt_q  <= PSC_RELOAD;
            psc_tick_q <= 1'b1;
        end else begin
            psc_cnt_q  <= psc_cnt_q - 4'h1;
            psc_tick_q <= 1'b0;
        end
    end

    // Range select on the top bits of the setting
    assign dt_len = deadtime_length(deadtime_setup_q);

    // ********************************************
    // Paired channels 1 to 3
    // ********************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            always_comb begin
                if (main_output_gate_q) begin
                    want[g].main = ref_wave_i[g]
                                   && channel_enables_q[2*g];
                    want[g].comp = !ref_wave_i[g]
                                   && channel_enables_q[2*g+1];
                end else begin
                    want[g].main = idle_bits[2*g];
                    want[g].comp = idle_bits[2*g+1];
                end
            end

            dtisc_deadtime_gen u_dtgen (
                .ref_clk_i  (ref_clk_i),
                .rst_i      (rst_i),
                .psc_tick_i (psc_tick_q),
                .dt_len_i   (dt_len),
                .want_i     (want[g]),
                .pair_o     (pair[g])
            );

            assign ch_main_out_o[g] = pair[g].main;
            assign ch_comp_out_o[g] = pair[g].comp;
        end
    endgenerate

    // ********************************************
    // Channel 4, no complementary output
    // ********************************************
    // Nothing to overlap with, so the idle level applies at once
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ch4_main_q <= 1'b0;
        end else if (main_output_gate_q) begin
            ch4_main_q <= ref_wave_i[3] && channel_enables_q[6];
        end else begin
            ch4_main_q <= idle_bits[6];
        end
    end

    assign ch_main_out_o[3] = ch4_main_q;

endmodule : dtisc_top

`default_nettype wire

// ==== verification/dtisc_props.sv ====
// Checker for the dead-time and idle-state block
`default_nettype none

module dtisc_props (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // APB slave
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Waveforms and power stage outputs
    input wire logic [3:0]  ref_wave_i,
    input wire logic [3:0]  ch_main_out_o,
    input wire logic [2:0]  ch_comp_out_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************************
    // Properties
    // ********************************************
    logic setup;
    logic mapped;
    assign setup  = psel_i && !penable_i;
    assign mapped = paddr_i[11:10] == 2'h0 && paddr_i[1:0] == 2'h0
        && (paddr_i[9:2] == 8'h00
        || (paddr_i[9:2] >= 8'h1e && paddr_i[9:2] <= 8'h22));

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_ready_after_setup: assert property (setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_ready_unasked: assert property (!psel_i |=> !pready_o)
        else $error("ready without request");
    a_error_decode: assert property (setup |=> pslverr_o == !$past(mapped))
        else $error("error flag wrong for address");
    a_error_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_idle_msb_zero: assert property (
        setup && !pwrite_i && paddr_i == 12'h07c |=> !prdata_o[7])
        else $error("idle register top bit set");
    a_pair_no_overlap: assert property (
        (ch_main_out_o[2:0] & ch_comp_out_o) == 3'h0)
        else $error("main and comp active together");
    a_reset_quiet: assert property ($fell(rst_i) |->
        ch_main_out_o == 4'h0 && ch_comp_out_o == 3'h0 && !pready_o)
        else $error("outputs active after reset");

    cover property (setup && pwrite_i);
    cover property (pslverr_o);
    cover property ($rose(ch_main_out_o[0]));

endmodule : dtisc_props

bind dtisc_top dtisc_props u_dtisc_props (
    .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ref_wave_i,
    .ch_main_out_o, .ch_comp_out_o
);

`default_nettype wire

// ==== verification/dtisc_power_stage.sv ====
// Power stage model fed by the main and complementary outputs
`default_nettype none

module dtisc_power_stage (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Gate drive from the block
    input  wire logic [3:0] main_i,
    input  wire logic [2:0] comp_i,
    // Fault count
    output logic      [7:0] shoot_cnt_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ********************************************
    // Shoot-through monitor
    // ********************************************
    // Both switches of one leg on would short the supply
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            shoot_cnt_o <= 8'h00;
        end else if (|(main_i[2:0] & comp_i)) begin
            shoot_cnt_o <= shoot_cnt_o + 8'h01;
        end
    end

endmodule : dtisc_power_stage

`default_nettype wire

// ==== verification/dtisc_tb_top.sv ====
// Testbench for the dead-time and idle-state block
`default_nettype none

module dtisc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk_i;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [3:0]  ref_wave_i;
    logic [3:0]  ch_main_out_o;
    logic [2:0]  ch_comp_out_o;
    logic [7:0]  shoots;
    int          n_errors;
    int          tests_run;

    dtisc_top u_dtisc_top (
        .ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ref_wave_i,
        .ch_main_out_o, .ch_comp_out_o
    );
    dtisc_power_stage u_dtisc_power_stage (
        .ref_clk_i, .rst_i, .main_i(ch_main_out_o),
        .comp_i(ch_comp_out_o), .shoot_cnt_o(shoots)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    // ********************************************
    // Tasks
    // ********************************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            finish_test();
        end
    endtask : guard

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi,
                           input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d",
                     what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge ref_clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= {24'h0, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        guard(n, 16);
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rc(input string what, input logic [11:0] a,
                      input logic [31:0] exp, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(what, exp, r);
        chk("error flag", {31'h0, xe}, {31'h0, e});
    endtask : rc

    task automatic outs(input logic [3:0] m, input logic [2:0] c);
        repeat (12) @(posedge ref_clk_i);
        chk("main outputs", {28'h0, m}, {28'h0, ch_main_out_o});
        chk("comp outputs", {29'h0, c}, {29'h0, ch_comp_out_o});
    endtask : outs

    task automatic do_reset;
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    function automatic int ticks(input logic [7:0] s);
        if (!s[7]) return int'(s);
        if (!s[6]) return (64 + int'(s[5:0])) * 2;
        if (!s[5]) return (32 + int'(s[4:0])) * 8;
        return (32 + int'(s[4:0])) * 16;
    endfunction : ticks

    // Edges from the reference rise until the main output rises
    task automatic measure(input logic [7:0] s);
        int n;
        int lo;
        wr(12'h078, s);
        lo = 2 * ticks(s);
        ref_wave_i <= 4'h1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ch_main_out_o[0] !== 1'b1 && n < 2100);
        guard(n, 2100);
        chk_rng("dead time", lo, lo + 4, n);
        ref_wave_i <= 4'h0;
        // Wait out the comp dead time so the next case starts settled
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ch_comp_out_o[0] !== 1'b1 && n < 2100);
        guard(n, 2100);
        chk_rng("comp dead time", lo, lo + 4, n);
    endtask : measure

    // Lock can only be raised once, so every level needs its own reset
    task automatic lock_case(input logic [1:0] lv);
        do_reset();
        wr(12'h078, 8'h03);
        wr(12'h07c, 8'h15);
        wr(12'h080, {6'h00, lv});
        outs(4'h7, 3'h0);
        wr(12'h078, 8'h44);
        wr(12'h07c, 8'h2a);
        wr(12'h080, {1'b1, 5'h00, ~lv});
        rc("locked dead time", 12'h078, 32'h03, 1'b0);
        rc("locked idle", 12'h07c, 32'h15, 1'b0);
        rc("lock level", 12'h080, {24'h0, 6'h20, lv}, 1'b0);
        outs(4'h0, 3'h0);
    endtask : lock_case

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        static logic [7:0] tbl [8] = '{8'h00, 8'h7f, 8'h80, 8'hbf,
                                8'hc0, 8'hdf, 8'he0, 8'hff};
        rst_i      = 1'b1;
        psel_i     = 1'b0;
        penable_i  = 1'b0;
        pwrite_i   = 1'b0;
        paddr_i    = 12'h000;
        pwdata_i   = 32'h0;
        ref_wave_i = 4'h0;
        n_errors   = 0;
        tests_run  = 0;
        do_reset();
        rc("control one", 12'h000, 32'h0, 1'b0);
        wr(12'h000, 8'ha5);
        rc("control one rw", 12'h000, 32'ha5, 1'b0);
        rc("dead time reset", 12'h078, 32'h0, 1'b0);
        rc("idle reset", 12'h07c, 32'h0, 1'b0);
        rc("unmapped", 12'h0f0, 32'h0, 1'b1);
        rc("misaligned", 12'h079, 32'h0, 1'b1);
        wr(12'h078, 8'h05);
        wr(12'h07c, 8'hd5);
        rc("idle top bit", 12'h07c, 32'h55, 1'b0);
        outs(4'hf, 3'h0);
        wr(12'h07c, 8'h2a);
        outs(4'h0, 3'h7);
        wr(12'h084, 8'h7f);
        rc("enables", 12'h084, 32'h7f, 1'b0);
        wr(12'h080, 8'h80);
        foreach (tbl[i]) begin
            measure(tbl[i]);
        end
        wr(12'h078, 8'h00);
        ref_wave_i <= 4'ha;
        outs(4'ha, 3'h5);
        wr(12'h080, 8'h03);
        wr(12'h078, 8'h11);
        rc("lock stays off", 12'h078, 32'h11, 1'b0);
        outs(4'h0, 3'h7);
        rc("output status", 12'h088, 32'h87, 1'b0);
        ref_wave_i <= 4'h0;
        for (int lv = 1; lv < 4; lv++) begin
            lock_case(lv[1:0]);
        end
        chk("shoot through", 32'h0, {24'h0, shoots});
        finish_test();
    end

endmodule : dtisc_tb_top

`default_nettype wire
